// file: hdl/rifm_pkg.sv
// constants and carrier types for the radio event flag and pin routing unit
package rifm_pkg;
    // register indexes; byte address is four times the index
    localparam logic [5:0] IDX_ROUTE_A = 6'h25;
    localparam logic [5:0] IDX_ROUTE_B = 6'h26;
    localparam logic [5:0] IDX_FLAGS_MODE = 6'h27;
    localparam logic [5:0] IDX_FLAGS_BUF = 6'h28;
    localparam logic [5:0] IDX_TRIG_LEVEL = 6'h29;
    localparam logic [5:0] IDX_RX_START_TMO = 6'h2A;
    localparam logic [5:0] IDX_POST_DET_TMO = 6'h2B;
    // reset values
    localparam logic [7:0] RST_ROUTE_A = 8'h00;
    localparam logic [3:0] RST_ROUTE_B = 4'h0;
    localparam logic [2:0] RST_CLK_SEL = 3'h7;
    localparam logic [7:0] RST_TRIG_LEVEL = 8'hE4;
    localparam logic [7:0] RST_TMO = 8'h00;
    localparam logic [7:0] RST_LOW_SUPPLY = 8'h00;
    // mode flag register bit positions
    localparam int B_OP_READY = 7;
    localparam int B_RX_READY = 6;
    localparam int B_TX_READY = 5;
    localparam int B_SYNTH_LOCK = 4;
    localparam int B_SIGNAL = 3;
    localparam int B_TIMEOUT = 2;
    localparam int B_AUTO_SEQ = 1;
    localparam int B_SYNC_HIT = 0;
    // buffer flag register bit positions
    localparam int B_BUF_FULL = 7;
    localparam int B_BUF_DATA = 6;
    localparam int B_BUF_LEVEL = 5;
    localparam int B_BUF_OVF = 4;
    localparam int B_FRAME_SENT = 3;
    localparam int B_FRAME_RCVD = 2;
    localparam int B_CRC_GOOD = 1;
    localparam int B_SUPPLY_LOW = 0;
    // route_b layout
    localparam int ROUTE_B_LSB = 4;
    // clock output codes
    localparam logic [2:0] CLK_UNDIV = 3'h0;
    localparam logic [2:0] CLK_DIV_MAX = 3'h5;
    localparam logic [2:0] CLK_RC = 3'h6;
    localparam logic [2:0] CLK_OFF = 3'h7;
    // buffer and timeout figures, and the apb byte lane
    localparam logic [6:0] BUF_FULL_COUNT = 7'h42;
    localparam int TMO_SCALE_SHIFT = 4;
    localparam logic [1:0] APB_BYTE_LANE = 2'h0;

    typedef enum logic [2:0] {
        MODE_SLEEP,
        MODE_STANDBY,
        MODE_SYNTH,
        MODE_RX,
        MODE_TX
    } rifm_mode_t;

    // status coming from the rest of the transceiver
    typedef struct packed {
        rifm_mode_t op_mode;
        logic intermediate_mode;
        logic continuous_mode;
        logic xo_running;
        logic pll_locked;
        logic rssi_sampling;
        logic rx_chain_done;
        logic pa_ramp_done;
        logic [7:0] signal_strength_value;
        logic signal_valid;
        logic sync_addr_detect;
        logic frame_sent_evt;
        logic last_byte_evt;
        logic crc_on;
        logic crc_ok_evt;
        logic checksum_fail_keep;
        logic [6:0] buffer_count;
        logic [6:0] buffer_threshold;
        logic overrun_evt;
        logic supply_below_thresh;
        logic bit_tick;
        logic xtal_tick;
        logic rc_osc;
    } rifm_evt_t;
endpackage

// file: hdl/rifm_top.sv
// event flags, pin routing, clock output select and receive timeouts behind apb
`timescale 1ns/1ps
//
// Contract
// - six 2-bit pin routing selects, reset zero
// - clock output select: divide, rc, off
// - op ready sets when mode reached, clears on change
// - rx ready after rx chain, clears leaving rx
// - tx ready after pa ramp, clears leaving tx
// - synth lock follows pll in synth/rx/tx
// - signal flag above trigger in rx, writable clear
// - timeout flag on expiry, clears rx exit/empty
// - auto sequence flag follows intermediate mode, lags sleep
// - sync hit flag, clear rules, continuous-only write clear
// - buffer full exactly at 66 bytes
// - buffer has data when count nonzero
// - buffer level when count above threshold
// - overflow flag outside sleep, write-one clears buffer
// - frame sent in tx, clears leaving tx
// - frame received after last byte, checksum gated
// - checksum good in rx, clears on empty
// - supply low sticky until software clears
// - trigger level reset e4, minus half dbm
// - start timeout value times 16 bit periods
// - post-detect timeout value times 16 bit periods
// - signal strength is half-db magnitude
// - checksum fail keep still raises frame received
module rifm_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rifm_pkg::rifm_evt_t evt,
    output logic [5:0] pin_out,
    output logic clock_output_pin,
    output logic rc_osc_enable,
    output logic buffer_clear
);
    function automatic logic [11:0] tmo_limit(input logic [7:0] v);
        tmo_limit = {v, 4'h0};
    endfunction

    function automatic logic pin_event(input logic [1:0] sel, input logic [3:0] ev);
        pin_event = ev[sel];
    endfunction

    // register bus
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [5:0] idx;
    logic addr_ok;
    logic wr_fire;
    logic [7:0] wdata;

    // software registers
    logic [7:0] route_a_q, route_a_d;
    logic [3:0] route_b_q, route_b_d;
    logic [2:0] clk_sel_q, clk_sel_d;
    logic [7:0] trig_q, trig_d;
    logic [7:0] tmo1_q, tmo1_d;
    logic [7:0] tmo2_q, tmo2_d;

    // flags
    logic [7:0] fm_q, fm_d;
    logic [7:0] fb_q, fb_d;
    rifm_pkg::rifm_mode_t mode_prev_q;
    logic inter_lag_q;
    logic [6:0] count_prev_q;
    logic buf_clear_q, buf_clear_d;

    // timeouts
    logic [11:0] cnt1_q, cnt1_d, cnt2_q, cnt2_d;
    logic done1_q, done1_d, done2_q, done2_d;
    logic armed2_q, armed2_d;
    logic run1, run2, hit1, hit2;

    // clock output and pins
    logic [4:0] div_cnt_q, div_cnt_d;
    logic clk_tog_q, clk_tog_d;
    logic clk_out_q, clk_out_d;
    logic rc_en_q, rc_en_d;
    logic [5:0] pin_q, pin_d;

    logic in_rx, mode_chg, rx_entry, emptied, sig_above, op_reached;

    always_comb
    begin
        idx = paddr[7:2];
        addr_ok = (paddr[1:0] == rifm_pkg::APB_BYTE_LANE) &&
            (idx >= rifm_pkg::IDX_ROUTE_A) && (idx <= rifm_pkg::IDX_POST_DET_TMO);
        wr_fire = psel && penable && pwrite && pready_q && !pslverr_q && pstrb[0];
        wdata = pwdata[7:0];
        pready_d = psel && penable && !pready_q;
        pslverr_d = pready_d && !addr_ok;
        prdata_d = prdata_q;
        if (pready_d)
        begin
            prdata_d = 32'h0000_0000;
            case (idx)
                rifm_pkg::IDX_ROUTE_A: prdata_d[7:0] = route_a_q;
                rifm_pkg::IDX_ROUTE_B: prdata_d[7:0] = {route_b_q, 1'b0, clk_sel_q};
                rifm_pkg::IDX_FLAGS_MODE: prdata_d[7:0] = fm_q;
                rifm_pkg::IDX_FLAGS_BUF: prdata_d[7:0] = fb_q;
                rifm_pkg::IDX_TRIG_LEVEL: prdata_d[7:0] = trig_q;
                rifm_pkg::IDX_RX_START_TMO: prdata_d[7:0] = tmo1_q;
                rifm_pkg::IDX_POST_DET_TMO: prdata_d[7:0] = tmo2_q;
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_comb
    begin
        route_a_d = route_a_q;
        route_b_d = route_b_q;
        clk_sel_d = clk_sel_q;
        trig_d = trig_q;
        tmo1_d = tmo1_q;
        tmo2_d = tmo2_q;
        if (wr_fire)
        begin
            case (idx)
                rifm_pkg::IDX_ROUTE_A: route_a_d = wdata;
                rifm_pkg::IDX_ROUTE_B:
                begin
                    route_b_d = wdata[7:rifm_pkg::ROUTE_B_LSB];
                    clk_sel_d = wdata[2:0];
                end
                rifm_pkg::IDX_TRIG_LEVEL: trig_d = wdata;
                rifm_pkg::IDX_RX_START_TMO: tmo1_d = wdata;
                rifm_pkg::IDX_POST_DET_TMO: tmo2_d = wdata;
                default: route_a_d = route_a_q;
            endcase
        end
    end

    // flag logic; a set in the same cycle as a clear wins, except op ready, which a mode change clears even when the new mode is reached
    always_comb
    begin
        in_rx = evt.op_mode == rifm_pkg::MODE_RX;
        mode_chg = evt.op_mode != mode_prev_q;
        rx_entry = in_rx && (mode_prev_q != rifm_pkg::MODE_RX);
        emptied = (count_prev_q != 7'h00) && (evt.buffer_count == 7'h00);
        // stronger signal is a smaller magnitude
        sig_above = evt.signal_valid && (evt.signal_strength_value < trig_q);
        case (evt.op_mode)
            rifm_pkg::MODE_SLEEP: op_reached = 1'b1;
            rifm_pkg::MODE_STANDBY: op_reached = evt.xo_running;
            rifm_pkg::MODE_SYNTH: op_reached = evt.pll_locked;
            rifm_pkg::MODE_RX: op_reached = evt.rssi_sampling;
            rifm_pkg::MODE_TX: op_reached = evt.pa_ramp_done;
            default: op_reached = 1'b0;
        endcase
        fm_d = fm_q;
        fb_d = fb_q;
        buf_clear_d = 1'b0;
        fm_d[rifm_pkg::B_OP_READY] = !mode_chg && (fm_q[rifm_pkg::B_OP_READY] || op_reached);
        fm_d[rifm_pkg::B_RX_READY] = in_rx &&
            (fm_q[rifm_pkg::B_RX_READY] || evt.rx_chain_done);
        fm_d[rifm_pkg::B_TX_READY] = (evt.op_mode == rifm_pkg::MODE_TX) &&
            (fm_q[rifm_pkg::B_TX_READY] || evt.pa_ramp_done);
        fm_d[rifm_pkg::B_SYNTH_LOCK] = evt.pll_locked && (evt.op_mode == rifm_pkg::MODE_SYNTH ||
            in_rx || evt.op_mode == rifm_pkg::MODE_TX);
        fm_d[rifm_pkg::B_AUTO_SEQ] = (evt.op_mode == rifm_pkg::MODE_SLEEP) ?
            inter_lag_q : evt.intermediate_mode;
        if (wr_fire && idx == rifm_pkg::IDX_FLAGS_MODE)
        begin
            if (wdata[rifm_pkg::B_SIGNAL])
                fm_d[rifm_pkg::B_SIGNAL] = 1'b0;
            if (wdata[rifm_pkg::B_SYNC_HIT] && evt.continuous_mode)
                fm_d[rifm_pkg::B_SYNC_HIT] = 1'b0;
        end
        if (!in_rx)
        begin
            fm_d[rifm_pkg::B_SIGNAL] = 1'b0;
            fm_d[rifm_pkg::B_TIMEOUT] = 1'b0;
            fm_d[rifm_pkg::B_SYNC_HIT] = 1'b0;
        end
        if (emptied)
        begin
            fm_d[rifm_pkg::B_TIMEOUT] = 1'b0;
            fm_d[rifm_pkg::B_SYNC_HIT] = 1'b0;
            fb_d[rifm_pkg::B_FRAME_RCVD] = 1'b0;
            fb_d[rifm_pkg::B_CRC_GOOD] = 1'b0;
        end
        if (in_rx && sig_above)
            fm_d[rifm_pkg::B_SIGNAL] = 1'b1;
        if (in_rx && (hit1 || hit2))
            fm_d[rifm_pkg::B_TIMEOUT] = 1'b1;
        if (in_rx && evt.sync_addr_detect)
            fm_d[rifm_pkg::B_SYNC_HIT] = 1'b1;
        fb_d[rifm_pkg::B_BUF_FULL] = evt.buffer_count == rifm_pkg::BUF_FULL_COUNT;
        fb_d[rifm_pkg::B_BUF_DATA] = evt.buffer_count != 7'h00;
        fb_d[rifm_pkg::B_BUF_LEVEL] = evt.buffer_count > evt.buffer_threshold;
        fb_d[rifm_pkg::B_FRAME_SENT] = (evt.op_mode == rifm_pkg::MODE_TX) &&
            (fb_q[rifm_pkg::B_FRAME_SENT] || evt.frame_sent_evt);
        if (wr_fire && idx == rifm_pkg::IDX_FLAGS_BUF)
        begin
            if (wdata[rifm_pkg::B_BUF_OVF])
            begin
                fb_d[rifm_pkg::B_BUF_OVF] = 1'b0;
                buf_clear_d = 1'b1;
            end
            if (wdata[rifm_pkg::B_SUPPLY_LOW])
                fb_d[rifm_pkg::B_SUPPLY_LOW] = 1'b0;
        end
        if (evt.overrun_evt && evt.op_mode != rifm_pkg::MODE_SLEEP)
            fb_d[rifm_pkg::B_BUF_OVF] = 1'b1;
        if (evt.supply_below_thresh)
            fb_d[rifm_pkg::B_SUPPLY_LOW] = 1'b1;
        if (in_rx && evt.last_byte_evt &&
            (!evt.crc_on || evt.checksum_fail_keep || evt.crc_ok_evt))
            fb_d[rifm_pkg::B_FRAME_RCVD] = 1'b1;
        if (in_rx && evt.crc_ok_evt)
            fb_d[rifm_pkg::B_CRC_GOOD] = 1'b1;
    end

    // receive timeouts counted in bit periods
    always_comb
    begin
        run1 = in_rx && !fm_q[rifm_pkg::B_SIGNAL] && (tmo1_q != 8'h00) && !done1_q;
        run2 = in_rx && armed2_q && !fb_q[rifm_pkg::B_FRAME_RCVD] &&
            (tmo2_q != 8'h00) && !done2_q;
        hit1 = run1 && (cnt1_q == tmo_limit(tmo1_q));
        hit2 = run2 && (cnt2_q == tmo_limit(tmo2_q));
        cnt1_d = cnt1_q;
        done1_d = done1_q || hit1;
        cnt2_d = cnt2_q;
        done2_d = done2_q || hit2;
        armed2_d = armed2_q;
        if (run1 && !hit1 && evt.bit_tick)
            cnt1_d = cnt1_q + 12'h001;
        if (run2 && !hit2 && evt.bit_tick)
            cnt2_d = cnt2_q + 12'h001;
        if (in_rx && sig_above && !fm_q[rifm_pkg::B_SIGNAL])
        begin
            armed2_d = 1'b1;
            cnt2_d = 12'h000;
            done2_d = 1'b0;
        end
        if (!in_rx || rx_entry)
        begin
            cnt1_d = 12'h000;
            done1_d = 1'b0;
            cnt2_d = 12'h000;
            done2_d = 1'b0;
            armed2_d = 1'b0;
        end
    end

    // clock output divider and pin routing
    always_comb
    begin
        div_cnt_d = div_cnt_q;
        clk_tog_d = clk_tog_q;
        clk_out_d = 1'b0;
        rc_en_d = clk_sel_q == rifm_pkg::CLK_RC;
        if (clk_sel_q == rifm_pkg::CLK_UNDIV)
            clk_out_d = evt.xtal_tick;
        else if (clk_sel_q <= rifm_pkg::CLK_DIV_MAX)
        begin
            if (evt.xtal_tick)
            begin
                if (div_cnt_q >= 5'((5'h01 << (clk_sel_q - 3'h1)) - 5'h01))
                begin
                    div_cnt_d = 5'h00;
                    clk_tog_d = !clk_tog_q;
                end
                else
                    div_cnt_d = div_cnt_q + 5'h01;
            end
            clk_out_d = clk_tog_q;
        end
        else if (clk_sel_q == rifm_pkg::CLK_RC)
            clk_out_d = evt.rc_osc;
        for (int i = 0; i < 4; i++)
            pin_d[i] = pin_event(route_a_q[7 - 2 * i -: 2],
                {fm_q[rifm_pkg::B_OP_READY], fm_q[rifm_pkg::B_SYNC_HIT],
                fb_q[rifm_pkg::B_BUF_LEVEL],
                fb_q[rifm_pkg::B_FRAME_RCVD] | fb_q[rifm_pkg::B_FRAME_SENT]});
        for (int i = 0; i < 2; i++)
            pin_d[4 + i] = pin_event(route_b_q[3 - 2 * i -: 2],
                {fm_q[rifm_pkg::B_OP_READY], fm_q[rifm_pkg::B_SYNC_HIT],
                fb_q[rifm_pkg::B_BUF_LEVEL],
                fb_q[rifm_pkg::B_FRAME_RCVD] | fb_q[rifm_pkg::B_FRAME_SENT]});
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            route_a_q <= rifm_pkg::RST_ROUTE_A;
            route_b_q <= rifm_pkg::RST_ROUTE_B;
            clk_sel_q <= rifm_pkg::RST_CLK_SEL;
            trig_q <= rifm_pkg::RST_TRIG_LEVEL;
            tmo1_q <= rifm_pkg::RST_TMO;
            tmo2_q <= rifm_pkg::RST_TMO;
            fm_q <= 8'h80;
            fb_q <= rifm_pkg::RST_LOW_SUPPLY;
            mode_prev_q <= rifm_pkg::MODE_SLEEP;
            inter_lag_q <= 1'b0;
            count_prev_q <= 7'h00;
            buf_clear_q <= 1'b0;
            cnt1_q <= 12'h000;
            cnt2_q <= 12'h000;
            done1_q <= 1'b0;
            done2_q <= 1'b0;
            armed2_q <= 1'b0;
            div_cnt_q <= 5'h00;
            clk_tog_q <= 1'b0;
            clk_out_q <= 1'b0;
            rc_en_q <= 1'b0;
            pin_q <= 6'h00;
        end
        else
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            route_a_q <= route_a_d;
            route_b_q <= route_b_d;
            clk_sel_q <= clk_sel_d;
            trig_q <= trig_d;
            tmo1_q <= tmo1_d;
            tmo2_q <= tmo2_d;
            fm_q <= fm_d;
            fb_q <= fb_d;
            mode_prev_q <= evt.op_mode;
            inter_lag_q <= evt.intermediate_mode;
            count_prev_q <= evt.buffer_count;
            buf_clear_q <= buf_clear_d;
            cnt1_q <= cnt1_d;
            cnt2_q <= cnt2_d;
            done1_q <= done1_d;
            done2_q <= done2_d;
            armed2_q <= armed2_d;
            div_cnt_q <= div_cnt_d;
            clk_tog_q <= clk_tog_d;
            clk_out_q <= clk_out_d;
            rc_en_q <= rc_en_d;
            pin_q <= pin_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pin_out = pin_q;
    assign clock_output_pin = clk_out_q;
    assign rc_osc_enable = rc_en_q;
    assign buffer_clear = buf_clear_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_ovf_clear_write;
        wr_fire && idx == rifm_pkg::IDX_FLAGS_BUF && wdata[rifm_pkg::B_BUF_OVF];
    endsequence
    sequence s_no_new_ovf;
        !(evt.overrun_evt && evt.op_mode != rifm_pkg::MODE_SLEEP);
    endsequence

    a_buf_full_exact: assert property (
        fb_q[rifm_pkg::B_BUF_FULL] == ($past(evt.buffer_count) == rifm_pkg::BUF_FULL_COUNT))
        else $error("buffer full flag wrong");
    a_buf_has_data: assert property (
        ##1 fb_q[rifm_pkg::B_BUF_DATA] == ($past(evt.buffer_count) != 7'h00))
        else $error("buffer data flag wrong");
    a_buf_level_cmp: assert property (
        ##1 fb_q[rifm_pkg::B_BUF_LEVEL] ==
        ($past(evt.buffer_count) > $past(evt.buffer_threshold)))
        else $error("buffer level flag wrong");
    a_op_ready_clear: assert property (
        (evt.op_mode != mode_prev_q) |=> !fm_q[rifm_pkg::B_OP_READY])
        else $error("op ready not cleared on mode change");
    a_rx_ready_leave: assert property (
        (evt.op_mode != rifm_pkg::MODE_RX) |=> !fm_q[rifm_pkg::B_RX_READY])
        else $error("rx ready set outside rx");
    a_tx_ready_set: assert property (
        (evt.op_mode == rifm_pkg::MODE_TX && evt.pa_ramp_done) |=> fm_q[rifm_pkg::B_TX_READY])
        else $error("tx ready not set");
    a_synth_lock_follow: assert property (
        (!evt.pll_locked || evt.op_mode == rifm_pkg::MODE_SLEEP) |=>
        !fm_q[rifm_pkg::B_SYNTH_LOCK])
        else $error("lock flag without lock");
    a_signal_set: assert property (
        (in_rx && sig_above) |=> fm_q[rifm_pkg::B_SIGNAL])
        else $error("signal flag not set");
    a_ovf_clear_pulse: assert property (
        s_ovf_clear_write ##0 s_no_new_ovf |=> buffer_clear && !fb_q[rifm_pkg::B_BUF_OVF]
        ##1 !buffer_clear)
        else $error("overflow clear sequence wrong");
    a_supply_low_hold: assert property (
        fb_q[rifm_pkg::B_SUPPLY_LOW] &&
        !(wr_fire && idx == rifm_pkg::IDX_FLAGS_BUF && wdata[rifm_pkg::B_SUPPLY_LOW])
        |=> fb_q[rifm_pkg::B_SUPPLY_LOW])
        else $error("supply low flag dropped");
    a_clk_off_low: assert property (
        (clk_sel_q == rifm_pkg::CLK_OFF) [*2] |-> !clock_output_pin && !rc_osc_enable)
        else $error("clock output not off");
    a_start_tmo_hit: assert property (
        hit1 |=> fm_q[rifm_pkg::B_TIMEOUT] && cnt1_q == tmo_limit(tmo1_q))
        else $error("start timeout not flagged");
endmodule

// file: sim/rifm_radio_model.sv
// radio side model: crystal and bit ticks, data buffer fill level
`timescale 1ns/1ps
module rifm_radio_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire rifm_pkg::rifm_evt_t evt_req,
    input wire logic buf_load,
    input wire logic [6:0] buf_level,
    input wire logic buffer_clear,
    output rifm_pkg::rifm_evt_t evt
);
    logic [2:0] tick_q;
    logic [6:0] count_q;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            tick_q <= 3'h0;
            count_q <= 7'h00;
        end
        else
        begin
            tick_q <= tick_q + 3'h1;
            if (buffer_clear)
                count_q <= 7'h00;
            else if (buf_load)
                count_q <= buf_level;
        end
    end
    always_comb
    begin
        evt = evt_req;
        evt.buffer_count = count_q;
        evt.xtal_tick = tick_q[0];
        evt.bit_tick = (tick_q[1:0] == 2'h3);
        evt.rc_osc = tick_q[2];
    end
endmodule

// file: sim/testbench.sv
// self-checking bench for the event flag and pin routing unit
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, err, pready, pslverr, clock_output_pin, rc_osc_enable;
    logic buffer_clear, buf_load, last;
    logic [7:0] paddr, rd, v, t;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [5:0] pin_out;
    logic [6:0] buf_level;
    logic [6:0] lv[7];
    logic [31:0] seed = 32'h0000_002B;
    rifm_pkg::rifm_evt_t ereq, evt;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    int r, e;
    always #2.5 core_clk = ~core_clk;
    rifm_top rifm_top_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt), .pin_out(pin_out),
        .clock_output_pin(clock_output_pin), .rc_osc_enable(rc_osc_enable),
        .buffer_clear(buffer_clear));
    rifm_radio_model rifm_radio_model_inst (.core_clk(core_clk), .rst_n(rst_n),
        .evt_req(ereq), .buf_load(buf_load), .buf_level(buf_level),
        .buffer_clear(buffer_clear), .evt(evt));
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] bufexp(input logic [6:0] c, input logic [6:0] th);
        return {c == 7'h42, c != 7'h00, c > th, 5'h00};
    endfunction
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdx(input logic [5:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        `CHK(rd, exp)
    endtask
    task automatic setbuf(input logic [6:0] c);
        @(posedge core_clk);
        buf_load <= 1'b1;
        buf_level <= c;
        @(posedge core_clk);
        buf_load <= 1'b0;
        waitc(3);
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            summarize();
        end
    end
    initial
    begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
        pstrb = 4'hF; ereq = '0; buf_load = 1'b0; buf_level = 7'h00;
        waitc(16);
        rst_n <= 1'b1;
        rdx(rifm_pkg::IDX_ROUTE_A, 8'h00);
        rdx(rifm_pkg::IDX_ROUTE_B, 8'h07);
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'h80);
        rdx(rifm_pkg::IDX_FLAGS_BUF, 8'h00);
        rdx(rifm_pkg::IDX_TRIG_LEVEL, 8'hE4);
        rdx(rifm_pkg::IDX_RX_START_TMO, 8'h00);
        rdx(rifm_pkg::IDX_POST_DET_TMO, 8'h00);
        apb(1'b0, 6'h30, 8'h00);
        `CHK(err, 1'b1)
        for (int i = 0; i < 6; i++)
        begin
            v = xs();
            apb(1'b1, rifm_pkg::IDX_ROUTE_A, v);
            rdx(rifm_pkg::IDX_ROUTE_A, v);
            apb(1'b1, rifm_pkg::IDX_ROUTE_B, v);
            rdx(rifm_pkg::IDX_ROUTE_B, v & 8'hF7);
            apb(1'b1, rifm_pkg::IDX_TRIG_LEVEL, v);
            rdx(rifm_pkg::IDX_TRIG_LEVEL, v);
            apb(1'b1, rifm_pkg::IDX_FLAGS_MODE, v);
            rdx(rifm_pkg::IDX_FLAGS_MODE, 8'h80);
        end
        apb(1'b1, rifm_pkg::IDX_ROUTE_A, 8'hC0);
        apb(1'b1, rifm_pkg::IDX_ROUTE_B, 8'hC7);
        waitc(2);
        `CHK({pin_out[4], pin_out[0]}, 2'b11)
        apb(1'b1, rifm_pkg::IDX_ROUTE_A, 8'h40);
        t = xs() & 8'h3F;
        ereq.buffer_threshold <= t[6:0];
        lv = '{7'h00, 7'h01, t[6:0], t[6:0] + 7'h01, 7'h41, 7'h42, 7'(xs() % 8'd67)};
        foreach (lv[i])
        begin
            setbuf(lv[i]);
            rdx(rifm_pkg::IDX_FLAGS_BUF, bufexp(lv[i], t[6:0]));
            `CHK(pin_out[0], lv[i] > t[6:0])
        end
        for (int m = 0; m < 2; m++)
        begin
            ereq.op_mode <= m ? rifm_pkg::MODE_SLEEP : rifm_pkg::MODE_STANDBY;
            setbuf(7'h0A);
            ereq.overrun_evt <= 1'b1;
            @(posedge core_clk);
            ereq.overrun_evt <= 1'b0;
            waitc(2);
            rdx(rifm_pkg::IDX_FLAGS_BUF, bufexp(7'h0A, t[6:0]) | (m ? 8'h00 : 8'h10));
            apb(1'b1, rifm_pkg::IDX_FLAGS_BUF, 8'h10);
            waitc(3);
            rdx(rifm_pkg::IDX_FLAGS_BUF, 8'h00);
        end
        setbuf(7'h00);
        ereq.supply_below_thresh <= 1'b1;
        @(posedge core_clk);
        ereq.supply_below_thresh <= 1'b0;
        rdx(rifm_pkg::IDX_FLAGS_BUF, 8'h01);
        apb(1'b1, rifm_pkg::IDX_FLAGS_BUF, 8'h01);
        rdx(rifm_pkg::IDX_FLAGS_BUF, 8'h00);
        ereq.op_mode <= rifm_pkg::MODE_STANDBY;
        waitc(3);
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'h00);
        ereq.xo_running <= 1'b1;
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'h80);
        apb(1'b1, rifm_pkg::IDX_TRIG_LEVEL, 8'h80);
        ereq.op_mode <= rifm_pkg::MODE_RX;
        ereq.signal_strength_value <= 8'h90;
        ereq.signal_valid <= 1'b1;
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'h00);
        ereq.signal_strength_value <= 8'h40;
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'h08);
        ereq.signal_valid <= 1'b0;
        apb(1'b1, rifm_pkg::IDX_FLAGS_MODE, 8'h08);
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'h00);
        ereq.signal_valid <= 1'b1;
        waitc(3);
        ereq.op_mode <= rifm_pkg::MODE_STANDBY;
        ereq.signal_valid <= 1'b0;
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'h80);
        apb(1'b1, rifm_pkg::IDX_RX_START_TMO, 8'h01);
        ereq.op_mode <= rifm_pkg::MODE_RX;
        waitc(40);
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'h00);
        waitc(40);
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'h04);
        ereq.op_mode <= rifm_pkg::MODE_STANDBY;
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'h80);
        ereq.op_mode <= rifm_pkg::MODE_TX;
        ereq.pll_locked <= 1'b1;
        ereq.pa_ramp_done <= 1'b1;
        ereq.frame_sent_evt <= 1'b1;
        waitc(3);
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'hB0);
        rdx(rifm_pkg::IDX_FLAGS_BUF, 8'h08);
        ereq.op_mode <= rifm_pkg::MODE_RX;
        ereq.pa_ramp_done <= 1'b0;
        ereq.frame_sent_evt <= 1'b0;
        ereq.rssi_sampling <= 1'b1;
        ereq.rx_chain_done <= 1'b1;
        waitc(3);
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'hD0);
        rdx(rifm_pkg::IDX_FLAGS_BUF, 8'h00);
        setbuf(7'h05);
        ereq.crc_on <= 1'b1;
        ereq.crc_ok_evt <= 1'b1;
        ereq.last_byte_evt <= 1'b1;
        ereq.sync_addr_detect <= 1'b1;
        @(posedge core_clk);
        ereq.crc_ok_evt <= 1'b0;
        ereq.last_byte_evt <= 1'b0;
        ereq.sync_addr_detect <= 1'b0;
        rdx(rifm_pkg::IDX_FLAGS_BUF, bufexp(7'h05, t[6:0]) | 8'h06);
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'hD1);
        setbuf(7'h00);
        rdx(rifm_pkg::IDX_FLAGS_BUF, 8'h00);
        rdx(rifm_pkg::IDX_FLAGS_MODE, 8'hD0);
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, rifm_pkg::IDX_ROUTE_B, 8'(c));
            waitc(4);
            r = 0;
            last = clock_output_pin;
            repeat (128)
            begin
                @(posedge core_clk);
                if (clock_output_pin === 1'b1 && last === 1'b0)
                    r++;
                last = clock_output_pin;
            end
            e = (c == 7) ? 0 : (c == 6) ? 16 : 128 >> (c + 1);
            `CHK(r >= e - 1 && r <= e + 1, 1'b1)
            `CHK(rc_osc_enable, c == 6)
        end
        summarize();
    end
endmodule
